//--- shared/zcdl_cfg.svh
`ifndef ZCDL_CFG_SVH
`define ZCDL_CFG_SVH

// ***************************************************************
// Register offsets (byte addresses)
// ***************************************************************
`define ZCDL_OFS_CTRL 12'h000
`define ZCDL_OFS_STAT 12'h004
`define ZCDL_OFS_CLR 12'h008
`define ZCDL_OFS_IEN 12'h00c
`define ZCDL_OFS_PRIO 12'h010
`define ZCDL_OFS_FLAG 12'h014

// ***************************************************************
// Control register field positions
// ***************************************************************
`define ZCDL_BIT_SOFT_ON 7
`define ZCDL_BIT_OUT 5
`define ZCDL_BIT_INVERT 4
`define ZCDL_BIT_RISE_EN 1
`define ZCDL_BIT_FALL_EN 0

// ***************************************************************
// Status / interrupt bit positions
// ***************************************************************
`define ZCDL_ST_CROSS 0
`define ZCDL_ST_RISE 1
`define ZCDL_ST_FALL 2

// Priority register bits
`define ZCDL_PR_SCHEME 0
`define ZCDL_PR_HIGH 1

// Reset values
`define ZCDL_CTRL_RST 8'h00
`define ZCDL_IEN_RST 3'h0
`define ZCDL_PRIO_RST 2'h0

// Synchroniser depth
`define ZCDL_SYNC_STAGES 2

`endif

//--- shared/zcdl_pkg.sv
package zcdl_pkg;

    // Bus slave phases
    typedef enum logic [0:0] {
        ZCDL_IDLE,
        ZCDL_DONE
    } zcdl_bus_state_type;

endpackage

//--- hw/zcdl_sync.sv
`timescale 1ns/1ps
`include "zcdl_cfg.svh"

// Two-flop synchroniser for the asynchronous comparator level
module zcdl_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic sync_out
);

    // Both stages of the chain in one packed struct
    typedef struct packed {
        logic [`ZCDL_SYNC_STAGES-1:0] chain;
    } zcdl_sync_state_type;

    zcdl_sync_state_type state_r;
    zcdl_sync_state_type state_nxt;

    // ***************************************************************
    // Shift the level in; only stage 1 reads stage 0
    // ***************************************************************
    always_comb begin
        state_nxt = state_r;
        state_nxt.chain = {state_r.chain[0], async_in};
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign sync_out = state_r.chain[`ZCDL_SYNC_STAGES-1];

endmodule

//--- hw/zcdl_edge.sv
`timescale 1ns/1ps

// Rising/falling detector on a synchronous level
module zcdl_edge (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic level,
    output logic rise,
    output logic fall
);

    // Previous sample of the level
    typedef struct packed {
        logic prev;
    } zcdl_edge_state_type;

    zcdl_edge_state_type state_r;
    zcdl_edge_state_type state_nxt;

    // ***************************************************************
    // Keep one sample of history
    // ***************************************************************
    always_comb begin
        state_nxt = state_r;
        state_nxt.prev = level;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Compare current against previous sample
    assign rise = level & ~state_r.prev;
    assign fall = ~level & state_r.prev;

endmodule

//--- hw/zcdl_top.sv
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "zcdl_cfg.svh"

module zcdl_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_sinking,
    input wire logic fuse_standby_sel,
    input wire logic crossing_irq_en,
    input wire logic periph_irq_en,
    input wire logic global_irq_en,
    input wire logic prio_scheme_en,
    output logic detector_active,
    output logic crossing_out,
    output logic irq_high,
    output logic irq_low,
    output logic irq
);

    // ***************************************************************
    // State of the block
    // ***************************************************************
    typedef struct packed {
        zcdl_pkg::zcdl_bus_state_type bus;  // Bus slave phase
        logic [31:0] rdata;                 // Read data register
        logic ready;                        // Access completion
        logic err;                          // Unmapped address answer
        logic soft_on;                      // Software enable
        logic invert;                       // Output polarity
        logic rise_en;                      // Rising gate
        logic fall_en;                      // Falling gate
        logic crossing_flag;                // Sticky crossing flag
        logic [2:0] stat;                   // Sticky event status
        logic [2:0] ien;                    // Event interrupt enable
        logic prio_high;                    // Crossing priority
        logic out;                          // Registered logic output
        logic active;                       // Detector enabled
        logic irq;                          // Level interrupt
        logic irq_hi;                       // High priority request
        logic irq_lo;                       // Low priority request
        logic fuse_r;                       // Fuse strap registered every cycle
    } zcdl_state_type;

    zcdl_state_type state_r;
    zcdl_state_type state_nxt;

    logic cmp_sync;         // Synchronised comparator level
    logic logic_level;      // Output after inversion
    logic rise;             // Rising event
    logic fall;             // Falling event
    logic fuse_sync;        // Synchronised fuse strap
    logic bus_wr;           // Write takes effect
    logic bus_rd;           // Read takes effect
    logic mapped;           // Address decodes
    logic inv_change;       // Polarity write changes value
    logic cross_evt;        // Enabled crossing event
    logic [2:0] evt;        // Status events
    logic [7:0] ctrl_rd;    // Control readback
    logic flag_clr;         // Software clear of crossing_flag

    // ***************************************************************
    // Comparator and fuse synchronisers
    // ***************************************************************
    zcdl_sync u_sync_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(cmp_sinking),
        .sync_out(cmp_sync)
    );

    zcdl_sync u_sync_fuse (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(fuse_standby_sel),
        .sync_out(fuse_sync)
    );

    // Polarity applied before edge detection
    assign logic_level = cmp_sync ^ state_r.invert;

    zcdl_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .level(logic_level),
        .rise(rise),
        .fall(fall)
    );

    // ***************************************************************
    // Bus decode
    // ***************************************************************
    assign bus_wr = psel & penable & pwrite & (state_r.bus == zcdl_pkg::ZCDL_IDLE);
    assign bus_rd = psel & penable & ~pwrite & (state_r.bus == zcdl_pkg::ZCDL_IDLE);
    assign mapped = (paddr == `ZCDL_OFS_CTRL) || (paddr == `ZCDL_OFS_STAT) ||
                    (paddr == `ZCDL_OFS_CLR) || (paddr == `ZCDL_OFS_IEN) ||
                    (paddr == `ZCDL_OFS_PRIO) || (paddr == `ZCDL_OFS_FLAG);
    assign inv_change = bus_wr && (paddr == `ZCDL_OFS_CTRL) &&
                        (pwdata[`ZCDL_BIT_INVERT] != state_r.invert);
    // Software clear of the sticky flag, watched by the assertions
    assign flag_clr = bus_wr && (paddr == `ZCDL_OFS_FLAG) && !pwdata[0];

    // Enabled edges; a polarity flip itself is one of them since the
    // level after inversion moves, independent of soft_on
    assign cross_evt = (rise & state_r.rise_en) | (fall & state_r.fall_en);
    assign evt = {fall, rise, cross_evt};

    // Control readback with output at bit 5
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[`ZCDL_BIT_SOFT_ON] = state_r.soft_on;
        ctrl_rd[`ZCDL_BIT_OUT] = state_r.out;
        ctrl_rd[`ZCDL_BIT_INVERT] = state_r.invert;
        ctrl_rd[`ZCDL_BIT_RISE_EN] = state_r.rise_en;
        ctrl_rd[`ZCDL_BIT_FALL_EN] = state_r.fall_en;
    end

    // ***************************************************************
    // Next state
    // ***************************************************************
    always_comb begin
        state_nxt = state_r;
        state_nxt.ready = 1'b0;
        state_nxt.err = 1'b0;
        // Bus phase: answer one cycle after the access phase starts
        case (state_r.bus)
            zcdl_pkg::ZCDL_IDLE: begin
                if (psel && penable) begin
                    state_nxt.bus = zcdl_pkg::ZCDL_DONE;
                    state_nxt.ready = 1'b1;
                    state_nxt.err = ~mapped;
                end
            end
            zcdl_pkg::ZCDL_DONE: begin
                state_nxt.bus = zcdl_pkg::ZCDL_IDLE;
            end
            default: begin
                state_nxt.bus = zcdl_pkg::ZCDL_IDLE;
            end
        endcase
        // Register writes
        if (bus_wr) begin
            case (paddr)
                `ZCDL_OFS_CTRL: begin
                    state_nxt.soft_on = pwdata[`ZCDL_BIT_SOFT_ON];
                    state_nxt.invert = pwdata[`ZCDL_BIT_INVERT];
                    state_nxt.rise_en = pwdata[`ZCDL_BIT_RISE_EN];
                    state_nxt.fall_en = pwdata[`ZCDL_BIT_FALL_EN];
                end
                `ZCDL_OFS_CLR: begin
                    state_nxt.stat = state_r.stat & ~pwdata[2:0];
                end
                `ZCDL_OFS_IEN: begin
                    state_nxt.ien = pwdata[2:0];
                end
                `ZCDL_OFS_PRIO: begin
                    state_nxt.prio_high = pwdata[`ZCDL_PR_HIGH];
                end
                `ZCDL_OFS_FLAG: begin
                    if (pwdata[0] == 1'b0) begin
                        state_nxt.crossing_flag = 1'b0;
                    end
                end
                default: begin
                    state_nxt.ien = state_r.ien;
                end
            endcase
        end
        // Events set after the clear so the set wins
        if (cross_evt) begin
            state_nxt.crossing_flag = 1'b1;
        end
        state_nxt.stat = state_nxt.stat | evt;
        // Register reads
        if (bus_rd) begin
            case (paddr)
                `ZCDL_OFS_CTRL: state_nxt.rdata = {24'h000000, ctrl_rd};
                `ZCDL_OFS_STAT: state_nxt.rdata = {29'h00000000, state_r.stat};
                `ZCDL_OFS_IEN: state_nxt.rdata = {29'h00000000, state_r.ien};
                `ZCDL_OFS_PRIO: state_nxt.rdata = {30'h00000000, state_r.prio_high, 1'b0};
                `ZCDL_OFS_FLAG: state_nxt.rdata = {31'h00000000, state_r.crossing_flag};
                default: state_nxt.rdata = 32'h00000000;
            endcase
        end
        // Output, enable and requests; no sleep input affects any of it
        state_nxt.out = logic_level;
        state_nxt.fuse_r = fuse_sync;
        state_nxt.active = ~state_r.fuse_r | state_r.soft_on;
        state_nxt.irq = |(state_nxt.stat & state_r.ien);
        state_nxt.irq_hi = state_nxt.crossing_flag & crossing_irq_en & periph_irq_en & global_irq_en &
                           (~prio_scheme_en | state_r.prio_high);
        state_nxt.irq_lo = state_nxt.crossing_flag & crossing_irq_en & periph_irq_en & global_irq_en &
                           prio_scheme_en & ~state_r.prio_high;
        if (inv_change) begin
            state_nxt.stat[`ZCDL_ST_CROSS] = 1'b1;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    assign prdata = state_r.rdata;
    assign pready = state_r.ready;
    assign pslverr = state_r.err;
    assign detector_active = state_r.active;
    assign crossing_out = state_r.out;
    assign irq_high = state_r.irq_hi;
    assign irq_low = state_r.irq_lo;
    assign irq = state_r.irq;

    // ***************************************************************
    // Assertions
    // ***************************************************************
    sequence s_clear_with_edge;
        bus_wr && (paddr == `ZCDL_OFS_FLAG) && !pwdata[0] && cross_evt;
    endsequence

    // Access phase taken by the idle slave
    sequence s_take;
        psel && penable && (state_r.bus == zcdl_pkg::ZCDL_IDLE);
    endsequence

    property p_out_tracks;
        @(posedge pclk) disable iff (!presetn) 1'b1 |=> crossing_out == $past(logic_level);
    endproperty
    a_out_tracks: assert property (p_out_tracks) else $error("Output not level");

    // Plain polarity: output follows the synchronised comparator
    property p_plain_polarity;
        @(posedge pclk) disable iff (!presetn) !state_r.invert |=> crossing_out == $past(cmp_sync);
    endproperty
    a_plain_polarity: assert property (p_plain_polarity) else $error("Plain polarity wrong");

    // Inverted polarity: output is the complement of the comparator
    property p_invert;
        @(posedge pclk) disable iff (!presetn) state_r.invert |=> crossing_out == !$past(cmp_sync);
    endproperty
    a_invert: assert property (p_invert) else $error("Inversion wrong");

    property p_rise_sets;
        @(posedge pclk) disable iff (!presetn) rise && state_r.rise_en |=> state_r.crossing_flag;
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("Rise lost");

    property p_fall_sets;
        @(posedge pclk) disable iff (!presetn) fall && state_r.fall_en |=> state_r.crossing_flag;
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("Fall lost");

    property p_set_wins;
        @(posedge pclk) disable iff (!presetn) s_clear_with_edge |=> state_r.crossing_flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Clear beat set");

    property p_no_event_quiet;
        @(posedge pclk) disable iff (!presetn)
            !state_r.crossing_flag && !cross_evt |=> !state_r.crossing_flag;
    endproperty
    a_no_event_quiet: assert property (p_no_event_quiet) else $error("Flag rose alone");

    property p_pulse_one;
        @(posedge pclk) disable iff (!presetn) rise |=> !rise;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("Rise too long");

    // Falling events last one cycle as well
    property p_fall_one;
        @(posedge pclk) disable iff (!presetn) fall |=> !fall;
    endproperty
    a_fall_one: assert property (p_fall_one) else $error("Fall too long");

    property p_sync_delay;
        @(posedge pclk) disable iff (!presetn) 1'b1 |=> ##1 cmp_sync == $past(cmp_sinking, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("Sync depth wrong");

    // Skip the release edge: the enable register still holds its reset value
    property p_fuse_on;
        @(posedge pclk) disable iff (!presetn) $past(presetn) && !state_r.fuse_r |=> detector_active;
    endproperty
    a_fuse_on: assert property (p_fuse_on) else $error("Always-on failed");

    property p_prio_low;
        @(posedge pclk) disable iff (!presetn) irq_low |-> !irq_high;
    endproperty
    a_prio_low: assert property (p_prio_low) else $error("Both priorities");

    // Flag is cleared only by a software write
    property p_flag_held;
        @(posedge pclk) disable iff (!presetn)
            state_r.crossing_flag && !flag_clr |=> state_r.crossing_flag;
    endproperty
    a_flag_held: assert property (p_flag_held) else $error("Flag dropped alone");

    // Polarity write that changes the value leaves an event in status
    property p_inv_event;
        @(posedge pclk) disable iff (!presetn) inv_change |=> state_r.stat[`ZCDL_ST_CROSS];
    endproperty
    a_inv_event: assert property (p_inv_event) else $error("Polarity event lost");

    // Access answered on the next edge
    property p_answer;
        @(posedge pclk) disable iff (!presetn) s_take |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("Access not answered");

    // Answer lasts one cycle
    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn) pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("Ready too long");

endmodule

//--- bench/zcdl_cmp_model.sv
`timescale 1ns/1ps

// ************************************************
// Comparator model: sink/source state of the pin
// ************************************************
module zcdl_cmp_model (
    output logic cmp_sinking
);
    // Pin starts out sourcing current
    initial begin
        cmp_sinking = 1'b0;
    end

    // Swing to a new state off any clock edge; a slow swing lags well behind the call
    task automatic swing(input logic lvl, input bit slow);
        if (slow) begin
            #370;
        end
        #17;
        cmp_sinking = lvl;
    endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
`include "zcdl_cfg.svh"

module testbench;
    // ************************************************
    // Stimulus and observed signals
    // ************************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cmp_sinking;
    logic fuse_standby_sel = 1'b0;
    logic crossing_irq_en = 1'b0;
    logic periph_irq_en = 1'b0;
    logic global_irq_en = 1'b0;
    logic prio_scheme_en = 1'b0;
    logic detector_active;
    logic crossing_out;
    logic irq_high;
    logic irq_low;
    logic irq;
    logic [31:0] rd_q; // Last read data
    logic err_q; // Last error response
    int fail_count = 0;
    int checked = 0;
    int cycles = 0; // Cycles since start
    localparam logic [11:0] ctrl_a = `ZCDL_OFS_CTRL;
    localparam logic [11:0] stat_a = `ZCDL_OFS_STAT;
    localparam logic [11:0] clr_a = `ZCDL_OFS_CLR;
    localparam logic [11:0] ien_a = `ZCDL_OFS_IEN;
    localparam logic [11:0] prio_a = `ZCDL_OFS_PRIO;
    localparam logic [11:0] flag_a = `ZCDL_OFS_FLAG;

    // Clock of 50 ns
    always #25 pclk = ~pclk;

    // ************************************************
    // Design and pin model
    // ************************************************
    zcdl_top uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_sinking(cmp_sinking), .fuse_standby_sel(fuse_standby_sel),
        .crossing_irq_en(crossing_irq_en), .periph_irq_en(periph_irq_en),
        .global_irq_en(global_irq_en), .prio_scheme_en(prio_scheme_en),
        .detector_active(detector_active), .crossing_out(crossing_out),
        .irq_high(irq_high), .irq_low(irq_low), .irq(irq)
    );
    zcdl_cmp_model cmp (.cmp_sinking(cmp_sinking));

    // ************************************************
    // Helper tasks
    // ************************************************
    // Verdict and end of run
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Compare one value
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One bus transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= adr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge pclk);
        end
        if (n == 16) begin
            fail_count++;
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Register write
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Register read and compare
    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd_q, exp);
    endtask

    // Let synchroniser and edge logic settle
    task automatic settle();
        repeat (8) @(posedge pclk);
    endtask

    // ************************************************
    // Hang guard
    // ************************************************
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            complete_run();
        end
    end

    // ************************************************
    // Test sequence
    // ************************************************
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        rdc("ctrl rst", ctrl_a, 32'h0);
        rdc("stat rst", stat_a, 32'h0);
        rdc("ien rst", ien_a, 32'h0);
        rdc("prio rst", prio_a, 32'h0);
        rdc("flag rst", flag_a, 32'h0);
        chk("active fuse0", {31'h0, detector_active}, 32'h1);
        rdc("unmapped", 12'h0fc, 32'h0);
        chk("slverr", {31'h0, err_q}, 32'h1);
        wr(ctrl_a, 32'h6c);
        rdc("ctrl ro", ctrl_a, 32'h0);
        // Plain polarity, no edge enables
        cmp.swing(1'b1, 1'b0);
        settle();
        chk("out sink", {31'h0, crossing_out}, 32'h1);
        rdc("ctrl out", ctrl_a, 32'h20);
        rdc("flag none", flag_a, 32'h0);
        cmp.swing(1'b0, 1'b0);
        settle();
        chk("out src", {31'h0, crossing_out}, 32'h0);
        // Rising edges only
        wr(ctrl_a, 32'h02);
        cmp.swing(1'b1, 1'b1);
        settle();
        rdc("flag rise", flag_a, 32'h1);
        wr(flag_a, 32'h1);
        rdc("flag w1", flag_a, 32'h1);
        wr(flag_a, 32'h0);
        cmp.swing(1'b0, 1'b0);
        settle();
        rdc("flag fall off", flag_a, 32'h0);
        // Falling edges only
        wr(ctrl_a, 32'h01);
        cmp.swing(1'b1, 1'b0);
        settle();
        rdc("flag rise off", flag_a, 32'h0);
        // Clear lands on the same edge as the enabled fall
        fork
            cmp.swing(1'b0, 1'b0);
            wr(flag_a, 32'h0);
        join
        settle();
        rdc("flag fall", flag_a, 32'h1);
        wr(flag_a, 32'h0);
        // Inversion while soft_on is clear
        wr(ctrl_a, 32'h13);
        settle();
        chk("inv out", {31'h0, crossing_out}, 32'h1);
        rdc("ctrl inv", ctrl_a, 32'h33);
        rdc("flag inv", flag_a, 32'h1);
        cmp.swing(1'b1, 1'b1);
        settle();
        chk("inv sink", {31'h0, crossing_out}, 32'h0);
        wr(ctrl_a, 32'h12);
        wr(flag_a, 32'h0);
        cmp.swing(1'b0, 1'b0);
        settle();
        rdc("flag inv rise", flag_a, 32'h1);
        // Status, enable and clear registers
        wr(ien_a, 32'h1);
        settle();
        chk("irq on", {31'h0, irq}, 32'h1);
        wr(stat_a, 32'h0);
        apb(1'b0, stat_a, 32'h0);
        chk("stat ro", rd_q, 32'h7);
        wr(ien_a, 32'h0);
        settle();
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(ien_a, 32'h1);
        wr(clr_a, 32'h7);
        rdc("stat clr", stat_a, 32'h0);
        settle();
        chk("irq clr", {31'h0, irq}, 32'h0);
        // Priority routing, all four enable inputs driven high by the bench
        crossing_irq_en <= 1'b1;
        periph_irq_en <= 1'b1;
        global_irq_en <= 1'b1;
        prio_scheme_en <= 1'b1;
        wr(prio_a, 32'h2);
        settle();
        chk("irq high", {30'h0, irq_high, irq_low}, 32'h2);
        wr(prio_a, 32'h0);
        settle();
        chk("irq low", {30'h0, irq_high, irq_low}, 32'h1);
        prio_scheme_en <= 1'b0;
        settle();
        chk("irq no scheme", {30'h0, irq_high, irq_low}, 32'h2);
        global_irq_en <= 1'b0;
        settle();
        chk("irq gated", {30'h0, irq_high, irq_low}, 32'h0);
        global_irq_en <= 1'b1;
        wr(flag_a, 32'h0);
        settle();
        chk("irq flag clr", {30'h0, irq_high, irq_low}, 32'h0);
        // Software enable when the strap asks for it
        fuse_standby_sel <= 1'b1;
        wr(ctrl_a, 32'h0);
        settle();
        chk("soft off", {31'h0, detector_active}, 32'h0);
        wr(ctrl_a, 32'h80);
        settle();
        chk("soft on", {31'h0, detector_active}, 32'h1);
        complete_run();
    end
endmodule
